// [urhpc_pkg.sv]
// package: register map, field positions and timing for the root hub port control block
package urhpc_pkg;
  localparam int unsigned CLK_HZ            = 20000000;
  localparam int unsigned MS_TICK_CYCLES    = CLK_HZ / 1000;
  localparam int unsigned RESET_TIME_MS     = 10;
  localparam int unsigned RESUME_PULSE_MS   = 20;
  localparam int unsigned RESYNC_TIME_MS    = 3;
  localparam int unsigned RESUME_TOTAL_MS   = RESUME_PULSE_MS + RESYNC_TIME_MS;
  // register byte addresses
  localparam logic [15:0] HUB_POWER_OFFS    = 16'hd050;
  localparam logic [15:0] PORT_STAT_OFFS    = 16'hd054;
  localparam logic [15:0] HUB_CFG_OFFS      = 16'hd0f0;
  // hub status bit positions
  localparam int unsigned HB_LOCAL_POWER    = 0;
  localparam int unsigned HB_OVERCURRENT    = 1;
  localparam int unsigned HB_POWER_ON       = 16;
  // port status bit positions
  localparam int unsigned PB_CONNECTED      = 0;
  localparam int unsigned PB_ENABLE         = 1;
  localparam int unsigned PB_SUSPEND        = 2;
  localparam int unsigned PB_OVERCURRENT    = 3;
  localparam int unsigned PB_RESET          = 4;
  localparam int unsigned PB_POWER          = 8;
  localparam int unsigned PB_SLOW           = 9;
  localparam int unsigned PB_CONN_CHG       = 16;
  localparam int unsigned PB_EN_CHG         = 17;
  localparam int unsigned PB_SUSP_CHG       = 18;
  localparam int unsigned PB_OC_CHG         = 19;
  localparam int unsigned PB_RST_CHG        = 20;
  // hub configuration bit positions
  localparam int unsigned CB_PER_PORT_SW    = 0;
  localparam int unsigned CB_NO_SWITCH      = 1;
  localparam int unsigned CB_PER_PORT_OC    = 2;
  localparam int unsigned CB_POWER_MASK     = 3;
  localparam int unsigned CB_FIXED_DEV      = 4;
  localparam logic [31:0] CFG_RESET         = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY         = 2'b00;
  localparam logic [1:0]  RESP_SLVERR       = 2'b10;

  typedef enum logic [1:0]
  {
    URHPC_IDLE   = 2'b00,
    URHPC_RESET  = 2'b01,
    URHPC_RESUME = 2'b10
  } urhpc_seq_t;

  // events coming from the attached device and the link engine
  typedef struct packed
  {
    logic connected;
    logic slow;
    logic overcurrent;
    logic babble;
  } urhpc_link_t;
endpackage

// [urhpc_top.sv]
// root hub port status and control logic with an axi4-lite slave
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Functional notes
// - hub overcurrent follows input, global reporting only
// - local power reads zero, one clears power
// - port writes wait for bus transaction end
// - reset done change set after 10 ms
// - per-port overcurrent change on indicator change
// - suspend change after resume, cleared by reset
// - enable change only on hardware disable
// - connect change on attach, detach, bad commands
// - fixed device: connect change after hub reset
// - speed bit reads one for low speed
// - write one to speed bit powers off
// - overcurrent clears port power, except with no switching
// - power commands gated by mode and mask
// - power off clears connect, enable, suspend, reset
// - no switching: power reads one, write sets
// - reset write starts reset, disconnected sets change
// - port overcurrent follows input, per-port only
// - write one to bit three starts resume
// - suspend write sets suspend, cleared on completion
// - hardware disable sets enable change
// - enable set at reset/resume end or write
// - bit zero reads connect, write clears enable
// - power mask selects per-port commands
// ----------------------------------------------------------------
module urhpc_top
  import urhpc_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clk_en,
  input  wire logic        i_resume_state,
  input  wire logic        i_bus_busy,
  input  wire urhpc_link_t i_link,
  input  wire logic [15:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [15:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             o_port_reset_signal,
  output logic             o_port_resume_signal,
  output logic             o_port_power
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  urhpc_link_t link_meta;
  urhpc_link_t link_sync;
  logic        busy_meta;
  logic        busy_sync;

  // pins come from the device side and the link engine clock
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      link_meta <= '0;
      link_sync <= '0;
      busy_meta <= 1'b0;
      busy_sync <= 1'b0;
    end
    else if (i_clk_en)
    begin
      link_meta <= i_link;
      link_sync <= link_meta;
      busy_meta <= i_bus_busy;
      busy_sync <= busy_meta;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic        aw_held;
  logic        w_held;
  logic [15:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        wr_fire;
  logic        port_pend;
  logic [31:0] port_cmd;
  logic        port_apply;
  logic [31:0] cfg;
  logic [31:0] rd_word;
  logic [31:0] port_rd;

  function automatic logic [31:0] urhpc_lane_mask(input logic [3:0] strb);
    urhpc_lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
  endfunction

  // a port write waits in port_pend, so hold back new writes until it lands;
  // no handshake while frozen, or an item would be taken and then lost
  assign s_axi_awready = i_clk_en && !aw_held && !s_axi_bvalid && !port_pend;
  assign s_axi_wready  = i_clk_en && !w_held && !s_axi_bvalid && !port_pend;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign s_axi_arready = i_clk_en && !s_axi_rvalid;

  // address and data are taken in either order
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 16'h0000;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end
    else if (i_clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata & urhpc_lane_mask(s_axi_wstrb);
        w_strb <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held <= 1'b0;
    end
  end

  // write response, and the configuration register
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      cfg          <= CFG_RESET;
    end
    else if (i_clk_en)
    begin
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == HUB_POWER_OFFS || aw_addr == PORT_STAT_OFFS ||
                         aw_addr == HUB_CFG_OFFS) ? RESP_OKAY : RESP_SLVERR;
        if (aw_addr == HUB_CFG_OFFS)
          cfg <= (cfg & ~urhpc_lane_mask(w_strb)) | w_data;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel: one cycle from address to data
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (i_clk_en)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        case (s_axi_araddr)
          HUB_POWER_OFFS: s_axi_rdata <= rd_word;
          PORT_STAT_OFFS: s_axi_rdata <= port_rd;
          HUB_CFG_OFFS:   s_axi_rdata <= cfg;
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic per_port_sw;
  logic no_switch;
  logic per_port_oc;
  logic port_masked;
  logic fixed_dev;
  logic hub_wr;
  logic glob_on;
  logic glob_off;

  assign per_port_sw = cfg[CB_PER_PORT_SW];
  assign no_switch   = cfg[CB_NO_SWITCH];
  assign per_port_oc = cfg[CB_PER_PORT_OC];
  assign port_masked = cfg[CB_POWER_MASK];
  assign fixed_dev   = cfg[CB_FIXED_DEV];
  assign hub_wr      = wr_fire && aw_addr == HUB_POWER_OFFS;

  // global commands reach unmasked ports, mask ignored in global mode
  // mask bit steers which command set applies
  assign glob_on  = hub_wr && w_data[HB_POWER_ON] && !(per_port_sw && port_masked);
  // write one to local power acts as global power off
  assign glob_off = hub_wr && w_data[HB_LOCAL_POWER] && !(per_port_sw && port_masked);

  // port writes are parked while a transaction is on the bus
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      port_pend <= 1'b0;
      port_cmd  <= 32'h0000_0000;
    end
    else if (i_clk_en)
    begin
      if (wr_fire && aw_addr == PORT_STAT_OFFS)
      begin
        port_pend <= 1'b1;
        port_cmd  <= w_data;
      end
      else if (port_apply)
        port_pend <= 1'b0;
    end
  end
  assign port_apply = port_pend && !busy_sync;

  // ----------------------------------------------------------------
  // millisecond tick and interval sequencer
  // ----------------------------------------------------------------
  logic [15:0] tick_cnt;
  logic        ms_tick;
  logic [4:0]  ms_cnt;
  urhpc_seq_t  seq;
  logic        reset_done;
  logic        resume_done;

  // tick derived from the system clock
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
      tick_cnt <= 16'h0000;
    else if (i_clk_en)
      tick_cnt <= (ms_tick || seq == URHPC_IDLE) ? 16'h0000 : tick_cnt + 16'h0001;
  end
  assign ms_tick = tick_cnt == 16'(MS_TICK_CYCLES - 1);

  // interval end is flagged when the ms count reaches its target
  // an interval cut short by power loss or detach never reports completion
  assign reset_done  = seq == URHPC_RESET && ms_tick && ms_cnt == 5'(RESET_TIME_MS - 1) &&
                       connected && !pwr_off;
  assign resume_done = seq == URHPC_RESUME && ms_tick && ms_cnt == 5'(RESUME_TOTAL_MS - 1) &&
                       connected && !pwr_off;

  // ----------------------------------------------------------------
  // port state
  // ----------------------------------------------------------------
  logic       power;
  logic       enable;
  logic       suspend;
  logic       rst_st;
  logic       conn_chg;
  logic       en_chg;
  logic       susp_chg;
  logic       oc_chg;
  logic       rst_chg;
  logic       conn_d;
  logic       oc_d;
  logic       first_cycle;
  logic       oc_now;
  logic       power_rd;
  logic       connected;
  logic       hw_disable;
  logic       cmd_reset;
  logic       cmd_enable;
  logic       cmd_suspend;
  logic       cmd_resume;
  logic       cmd_pwr_on;
  logic       cmd_pwr_off;
  logic       pwr_on;
  logic       pwr_off;

  assign connected   = power_rd && link_sync.connected;
  assign oc_now      = link_sync.overcurrent;
  assign power_rd    = no_switch || power;
  assign cmd_reset   = port_apply && port_cmd[PB_RESET];
  assign cmd_enable  = port_apply && port_cmd[PB_ENABLE];
  assign cmd_suspend = port_apply && port_cmd[PB_SUSPEND];
  // bit three write starts resume only when suspended
  assign cmd_resume  = port_apply && port_cmd[PB_OVERCURRENT] && suspend && seq == URHPC_IDLE;
  // power write sets power; honoured when masked per-port or with no switching
  assign cmd_pwr_on  = port_apply && port_cmd[PB_POWER] && (no_switch || (per_port_sw && port_masked));
  // speed bit write powers the port down
  assign cmd_pwr_off = port_apply && port_cmd[PB_SLOW] && per_port_sw && port_masked;
  assign pwr_on      = cmd_pwr_on || glob_on;
  assign pwr_off     = !no_switch && (cmd_pwr_off || glob_off || oc_now);
  // hardware disable: overcurrent, detach, power off, babble
  assign hw_disable  = enable && (oc_now || !connected || pwr_off || link_sync.babble);

  // sequencer: reset and resume intervals
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      seq    <= URHPC_IDLE;
      ms_cnt <= 5'h00;
    end
    else if (i_clk_en)
    begin
      case (seq)
        URHPC_IDLE:
        begin
          ms_cnt <= 5'h00;
          // reset only starts on a connected port
          if (cmd_reset && connected)
            seq <= URHPC_RESET;
          else if (cmd_resume)
            seq <= URHPC_RESUME;
        end
        URHPC_RESET, URHPC_RESUME:
        begin
          if (pwr_off || !connected || reset_done || resume_done)
            seq <= URHPC_IDLE;
          else if (ms_tick)
            ms_cnt <= ms_cnt + 5'h01;
        end
        default: seq <= URHPC_IDLE;
      endcase
    end
  end

  // status bits cleared when power is removed
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      power   <= 1'b0;
      enable  <= 1'b0;
      suspend <= 1'b0;
      rst_st  <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (pwr_off)
        power <= 1'b0;
      else if (pwr_on)
        power <= 1'b1;
      // enable at reset or resume end, or on write
      if (pwr_off || hw_disable || (port_apply && port_cmd[PB_CONNECTED]))
        enable <= 1'b0;
      else if (reset_done || resume_done || (cmd_enable && connected))
        enable <= 1'b1;
      // suspend set on write, cleared at completion
      if (pwr_off || !connected || reset_done || resume_done || i_resume_state)
        suspend <= 1'b0;
      else if (cmd_suspend)
        suspend <= 1'b1;
      // reset status clears with reset done change
      if (pwr_off || !connected || reset_done)
        rst_st <= 1'b0;
      else if (cmd_reset)
        rst_st <= 1'b1;
    end
  end

  // change flags: hardware set wins over software clear
  always_ff @(posedge i_sys_clk)
  begin
    if (i_sys_rst)
    begin
      conn_chg    <= 1'b0;
      en_chg      <= 1'b0;
      susp_chg    <= 1'b0;
      oc_chg      <= 1'b0;
      rst_chg     <= 1'b0;
      conn_d      <= 1'b0;
      oc_d        <= 1'b0;
      first_cycle <= 1'b1;
    end
    else if (i_clk_en)
    begin
      conn_d      <= connected;
      oc_d        <= oc_now;
      // the fixed-device report waits until software has marked the port
      if (fixed_dev)
        first_cycle <= 1'b0;
      // attach, detach and commands on a detached port
      // fixed device reports once after hub reset
      if ((fixed_dev ? first_cycle : (connected != conn_d)) ||
          (!connected && (cmd_reset || cmd_enable || cmd_suspend)))
        conn_chg <= 1'b1;
      else if (port_apply && port_cmd[PB_CONN_CHG])
        conn_chg <= 1'b0;
      // only hardware disables set the flag
      if (hw_disable)
        en_chg <= 1'b1;
      else if (port_apply && port_cmd[PB_EN_CHG])
        en_chg <= 1'b0;
      // set at resume end, cleared when reset completes
      if (resume_done)
        susp_chg <= 1'b1;
      else if (reset_done || (port_apply && port_cmd[PB_SUSP_CHG]))
        susp_chg <= 1'b0;
      if (per_port_oc && oc_now != oc_d)
        oc_chg <= 1'b1;
      else if (port_apply && port_cmd[PB_OC_CHG])
        oc_chg <= 1'b0;
      // set at end of reset interval
      if (reset_done)
        rst_chg <= 1'b1;
      else if (port_apply && port_cmd[PB_RST_CHG])
        rst_chg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // read words and outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    port_rd = 32'h0000_0000;
    // bit zero shows the connection; fixed device always reads connected
    port_rd[PB_CONNECTED]   = connected || fixed_dev;
    port_rd[PB_ENABLE]      = enable;
    port_rd[PB_SUSPEND]     = suspend;
    // follows the input under per-port reporting
    port_rd[PB_OVERCURRENT] = per_port_oc && oc_now;
    port_rd[PB_RESET]       = rst_st;
    // reads one when switching is absent
    port_rd[PB_POWER]       = power_rd;
    // one for a low speed device
    port_rd[PB_SLOW]        = connected && link_sync.slow;
    port_rd[PB_CONN_CHG]    = conn_chg;
    port_rd[PB_EN_CHG]      = en_chg;
    port_rd[PB_SUSP_CHG]    = susp_chg;
    port_rd[PB_OC_CHG]      = oc_chg;
    port_rd[PB_RST_CHG]     = rst_chg;
    rd_word = 32'h0000_0000;
    // global indicator; local power stays zero
    rd_word[HB_OVERCURRENT] = !per_port_oc && oc_now;
  end

  assign o_port_reset_signal  = rst_st;
  assign o_port_resume_signal = seq == URHPC_RESUME;
  assign o_port_power         = power_rd;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  a_reset_done_sets: assert property (i_clk_en && reset_done |=> rst_chg && !rst_st)
    else $error("reset done change not set");
  a_susp_flag_set: assert property (i_clk_en && resume_done |=> susp_chg && enable)
    else $error("suspend change or enable missing after resume");
  a_no_sw_enchg: assert property (i_clk_en && !en_chg && !hw_disable |=> !en_chg)
    else $error("enable change set without hardware event");
  // a parked port write, and a read of the hub word
  sequence s_write_parked;
    i_clk_en && port_pend && busy_sync;
  endsequence
  sequence s_hub_read;
    i_clk_en && s_axi_arvalid && s_axi_arready && s_axi_araddr == HUB_POWER_OFFS;
  endsequence
  a_pending_busy: assert property (s_write_parked |=> port_pend)
    else $error("port write applied during transaction");
  a_oc_power_off: assert property (i_clk_en && oc_now && !no_switch |=> !power)
    else $error("power stays on during overcurrent");
  a_local_zero: assert property (s_hub_read |=> !s_axi_rdata[HB_LOCAL_POWER])
    else $error("local power bit reads one");
  a_power_off_clear: assert property (i_clk_en && pwr_off |=> !enable && !suspend && !rst_st)
    else $error("status kept after power off");
  a_detached_cmd: assert property (i_clk_en && !connected && cmd_reset |=> conn_chg && !rst_st)
    else $error("reset accepted on detached port");
endmodule

// [urhpc_dev_model.sv]
// behavioural model of the device plugged into the downstream port
`timescale 1ns/1ns
module urhpc_dev_model
  import urhpc_pkg::*;
(
  input  wire logic  i_sys_clk,
  output urhpc_link_t o_link
);
  initial o_link = '0;
  // ----------------------------------------
  // event tasks, applied right after an edge
  // ----------------------------------------
  task automatic plug(input logic slow);
    @(posedge i_sys_clk);
    o_link.connected <= 1'b1;
    o_link.slow      <= slow;
  endtask
  task automatic oc(input logic v);
    @(posedge i_sys_clk);
    o_link.overcurrent <= v;
  endtask
  // babble lasts a few cycles so the synchronisers see it
  task automatic bab();
    @(posedge i_sys_clk);
    o_link.babble <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    o_link.babble <= 1'b0;
  endtask
endmodule

// [testbench.sv]
// self-checking bench for the root hub port control block
`timescale 1ns/1ns
module testbench;
  import urhpc_pkg::*;
  logic i_sys_clk, i_sys_rst, i_clk_en, i_resume_state, i_bus_busy;
  urhpc_link_t i_link;
  logic [15:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic o_port_reset_signal, o_port_resume_signal, o_port_power;
  int failures = 0;
  int num_checks = 0;
  urhpc_top urhpc_top_i (.i_sys_clk, .i_sys_rst, .i_clk_en, .i_resume_state, .i_bus_busy,
    .i_link, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .o_port_reset_signal, .o_port_resume_signal, .o_port_power);
  urhpc_dev_model urhpc_dev_model_i (.i_sys_clk, .o_link(i_link));
  // ----------------------------------------
  // clock, reset and watchdog
  // ----------------------------------------
  initial
  begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // a run needs a few hundred cycles; this bound only catches a hang
  initial
  begin
    repeat (20000) @(posedge i_sys_clk);
    failures++;
    summarize();
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  function automatic logic [31:0] b(input int p);
    return 32'h1 << p;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  // every handshake is sampled at the rising edge and answered by nba there
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge i_sys_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge i_sys_clk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bready && s_axi_bvalid;
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) s_axi_bready <= 1'b0;
    end
    while (!bh);
  endtask
  task automatic rd(input logic [15:0] a);
    logic ah, rh;
    @(posedge i_sys_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge i_sys_clk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) s_axi_rready <= 1'b0;
    end
    while (!rh);
  endtask
  task automatic rp(input logic [31:0] m, input logic [31:0] e);
    rd(PORT_STAT_OFFS);
    chk(rv & m, e);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // commands on an empty port only flag a connect change
  task automatic s_empty();
    rp(32'hffff_ffff, 32'h0);
    rd(HUB_POWER_OFFS);
    chk(rv, 32'h0);
    rd(16'h0ff0);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR});
    wr(PORT_STAT_OFFS, b(PB_RESET) | b(PB_ENABLE) | b(PB_SUSPEND));
    rp(32'h0001_0016, b(PB_CONN_CHG));
    chk(o_port_reset_signal, 1'b0);
    wr(PORT_STAT_OFFS, b(PB_CONN_CHG));
    rp(b(PB_CONN_CHG), 32'h0);
  endtask
  // global mode ignores per-port power commands, masked per-port mode the global ones
  task automatic s_power();
    wr(HUB_POWER_OFFS, b(HB_POWER_ON));
    rp(b(PB_POWER), b(PB_POWER));
    wr(PORT_STAT_OFFS, b(PB_SLOW));
    rp(b(PB_POWER), b(PB_POWER));
    chk(o_port_power, 1'b1);
    wr(HUB_CFG_OFFS, b(CB_PER_PORT_SW) | b(CB_POWER_MASK));
    wr(PORT_STAT_OFFS, b(PB_SLOW));
    rp(b(PB_POWER), 32'h0);
    chk(o_port_power, 1'b0);
    wr(PORT_STAT_OFFS, b(PB_POWER));
    wr(HUB_POWER_OFFS, b(HB_LOCAL_POWER));
    rp(b(PB_POWER), b(PB_POWER));
    wr(HUB_CFG_OFFS, 32'h0);
  endtask
  task automatic s_enable();
    urhpc_dev_model_i.plug(1'b1);
    repeat (6) @(posedge i_sys_clk);
    rp(b(PB_CONNECTED) | b(PB_SLOW) | b(PB_CONN_CHG), 32'h0001_0201);
    wr(PORT_STAT_OFFS, b(PB_CONN_CHG) | b(PB_ENABLE));
    rp(b(PB_ENABLE) | b(PB_EN_CHG) | b(PB_CONN_CHG), b(PB_ENABLE));
    wr(PORT_STAT_OFFS, b(PB_CONNECTED));
    rp(b(PB_CONNECTED) | b(PB_ENABLE) | b(PB_EN_CHG), b(PB_CONNECTED));
    i_bus_busy <= 1'b1;
    wr(PORT_STAT_OFFS, b(PB_ENABLE));
    repeat (4) @(posedge i_sys_clk);
    rp(b(PB_ENABLE), 32'h0);
    i_bus_busy <= 1'b0;
    repeat (6) @(posedge i_sys_clk);
    rp(b(PB_ENABLE), b(PB_ENABLE));
    urhpc_dev_model_i.bab();
    repeat (6) @(posedge i_sys_clk);
    rp(b(PB_ENABLE) | b(PB_EN_CHG), b(PB_EN_CHG));
  endtask
  // resume starts only from suspend; controller resume state clears suspend
  task automatic s_suspend();
    wr(PORT_STAT_OFFS, b(PB_OVERCURRENT));
    chk(o_port_resume_signal, 1'b0);
    wr(PORT_STAT_OFFS, b(PB_SUSPEND));
    rp(b(PB_SUSPEND), b(PB_SUSPEND));
    i_resume_state <= 1'b1;
    repeat (3) @(posedge i_sys_clk);
    i_resume_state <= 1'b0;
    rp(b(PB_SUSPEND), 32'h0);
    wr(PORT_STAT_OFFS, b(PB_SUSPEND));
    wr(PORT_STAT_OFFS, b(PB_OVERCURRENT));
    @(posedge i_sys_clk);
    chk(o_port_resume_signal, 1'b1);
  endtask
  task automatic s_overcurrent();
    wr(HUB_POWER_OFFS, b(HB_LOCAL_POWER));
    rp(b(PB_POWER) | b(PB_CONNECTED), 32'h0);
    wr(HUB_POWER_OFFS, b(HB_POWER_ON));
    wr(PORT_STAT_OFFS, b(PB_RESET));
    @(posedge i_sys_clk);
    chk(o_port_reset_signal, 1'b1);
    urhpc_dev_model_i.oc(1'b1);
    repeat (6) @(posedge i_sys_clk);
    rd(HUB_POWER_OFFS);
    chk(rv & b(HB_OVERCURRENT), b(HB_OVERCURRENT));
    rp(b(PB_OVERCURRENT) | b(PB_POWER), 32'h0);
    chk(o_port_power, 1'b0);
    chk(o_port_reset_signal, 1'b0);
    urhpc_dev_model_i.oc(1'b0);
    wr(HUB_CFG_OFFS, b(CB_PER_PORT_OC));
    urhpc_dev_model_i.oc(1'b1);
    repeat (6) @(posedge i_sys_clk);
    rp(b(PB_OVERCURRENT) | b(PB_OC_CHG), b(PB_OVERCURRENT) | b(PB_OC_CHG));
    rd(HUB_POWER_OFFS);
    chk(rv & b(HB_OVERCURRENT), 32'h0);
    wr(PORT_STAT_OFFS, b(PB_OC_CHG));
    rp(b(PB_OC_CHG), 32'h0);
    wr(HUB_CFG_OFFS, b(CB_NO_SWITCH));
    rp(b(PB_POWER), b(PB_POWER));
    wr(PORT_STAT_OFFS, b(PB_CONN_CHG));
    wr(HUB_CFG_OFFS, b(CB_NO_SWITCH) | b(CB_FIXED_DEV));
    rp(b(PB_CONNECTED) | b(PB_CONN_CHG), b(PB_CONNECTED) | b(PB_CONN_CHG));
    wr(PORT_STAT_OFFS, b(PB_CONN_CHG));
    rp(b(PB_CONN_CHG), 32'h0);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    i_sys_rst = 1'b1;
    i_clk_en = 1'b1;
    i_resume_state = 1'b0;
    i_bus_busy = 1'b0;
    s_axi_awaddr = 16'h0000;
    s_axi_araddr = 16'h0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (16) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    s_empty();
    s_power();
    s_enable();
    s_suspend();
    s_overcurrent();
    summarize();
  end
endmodule
